//--- core/swc_sleep_wakeup_control.sv
// Notes on behaviour
// RULE1: Reset pin pulled low while asleep gives a full device reset.
// RULE2: Watchdog or enabled interrupt wake resumes the program, no reset.
// RULE3: Powerdown flag set at power-up, cleared when sleep takes effect.
// RULE4: Timeout flag cleared when watchdog expiry wakes the device.
// RULE5: Nine listed clockless peripheral sources are accepted as wake sources.
// RULE6: Clock-dependent peripherals cannot raise wake interrupts while asleep.
// RULE7: Next instruction is prefetched while the sleep instruction executes.
// RULE8: Source wakes only if individually enabled, whatever the global enable.
// RULE9: Global enable clear: continue in line after the sleep instruction.
// RULE10: Global enable set: run prefetched instruction, then branch to vector 0004h.
// RULE11: Enabled flag already set before sleep: sleep is a no-op, flags untouched.
// RULE12: Interrupt during or after sleep: sleep completes, then immediate wake.
// RULE13: Watchdog is cleared on every wake, whatever the source; reset-pin wake raises deviceReset with no wdtClear pulse.
// RULE14: Crystal modes hold execution 1024 oscillator periods after wake.
// RULE15: Software clears the watchdog before sleep and checks powerdown flag after.
// RULE16: Sleep stops main oscillator driver, Timer1 oscillator runs, I/O holds.
// RULE17: Core clock stays gated asleep until a wake condition or reset.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module swc_sleep_wakeup_control (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // AXI4-Lite write channels
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [4:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read channels
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [4:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Core side
    input  wire logic        sleepInstr,
    output logic             prefetchReq,
    output logic             coreClkEn,
    output logic             resumeCore,
    output logic             takeVector,
    output logic [12:0]      vectorAddr,
    output logic             deviceReset,
    output logic             timeoutFlag,
    output logic             powerdownFlag,
    // Wake sources and the clocked interrupt, which cannot wake
    input  wire logic        extResetPinN,
    input  wire logic        wdtTimeout,
    input  wire logic [8:0]  srcFlag,
    input  wire logic        clockedIrq,
    // Clocks, watchdog, pins
    output logic             wdtClear,
    output logic             oscDriverEn,
    output logic             ioHold,
    // Interrupt
    output logic             irq
);
    swc_pkg::swc_state_t state;
    swc_pkg::swc_state_t next_state;

    logic [3:0]  ctrl;
    logic [8:0]  srcEn;
    logic [4:0]  evStat;
    logic [4:0]  evEn;
    logic        awHeld;
    logic        wHeld;
    logic [4:0]  wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic        pendPrev;
    logic        wakeByIrq;
    logic        ostBusy;
    logic        ostDone;

    logic [3:0]  next_ctrl;
    logic [8:0]  next_srcEn;
    logic [4:0]  next_evStat;
    logic [4:0]  next_evEn;
    logic        next_awHeld;
    logic        next_wHeld;
    logic [4:0]  next_wrAddr;
    logic [31:0] next_wrData;
    logic [3:0]  next_wrStrb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_irq;
    logic        next_pendPrev;
    logic        next_wakeByIrq;
    logic        next_prefetchReq;
    logic        next_coreClkEn;
    logic        next_resumeCore;
    logic        next_takeVector;
    logic        next_deviceReset;
    logic        next_timeoutFlag;
    logic        next_powerdownFlag;
    logic        next_wdtClear;
    logic        next_oscDriverEn;
    logic        next_ioHold;
    logic        ostStart;
    logic [4:0]  evSet;
    logic [4:0]  evClr;
    logic [31:0] wMask;
    logic [31:0] ctrlWord;
    logic [31:0] srcWord;
    logic [31:0] evEnWord;

    wire logic       global_irq_enable      = ctrl[swc_pkg::CTRL_GIE];
    wire logic [2:0] oscMode  = ctrl[swc_pkg::CTRL_MODE_LO +: 3];
    wire logic       crystal  = (oscMode == swc_pkg::MODE_CRYSTAL) || (oscMode == swc_pkg::MODE_HS_CRYSTAL)
                                || (oscMode == swc_pkg::MODE_LP_CRYSTAL);
    // Only the nine clockless sources may wake; clockedIrq is left out here
    wire logic       irqWake  = |(srcFlag & srcEn); // RULE5 RULE6 RULE8
    wire logic       inOst    = (state == swc_pkg::ST_OST);
    wire logic       doWrite  = awHeld && wHeld && !bvalid;

    swc_ost_timer u_ost (
        .mclk  (mclk),
        .nrst  (nrst),
        .start (ostStart),
        .busy  (ostBusy),
        .done  (ostDone)
    );

    // Byte lanes of the held write
    always_comb begin
        wMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
        ctrlWord = ({28'h0000000, ctrl} & ~wMask) | (wrData & wMask);
        srcWord  = ({23'h000000, srcEn} & ~wMask) | (wrData & wMask);
        evEnWord = ({27'h0000000, evEn} & ~wMask) | (wrData & wMask);
    end

    // Bus slave: address and data taken in either order, answered once both held
    always_comb begin
        next_awHeld  = awHeld;
        next_wHeld   = wHeld;
        next_wrAddr  = wrAddr;
        next_wrData  = wrData;
        next_wrStrb  = wrStrb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_ctrl    = ctrl;
        next_srcEn   = srcEn;
        next_evEn    = evEn;
        evClr        = 5'h00;
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_wrAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld  = 1'b1;
            next_wrData = wdata;
            next_wrStrb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = swc_pkg::RESP_OKAY;
            case (wrAddr)
                swc_pkg::OFF_CTRL:    next_ctrl  = ctrlWord[3:0];
                swc_pkg::OFF_SRC_EN:  next_srcEn = srcWord[8:0];
                swc_pkg::OFF_EV_EN:   next_evEn  = evEnWord[4:0];
                swc_pkg::OFF_EV_CLR:  evClr      = wrData[4:0] & {5{wrStrb[0]}};
                swc_pkg::OFF_STATUS,
                swc_pkg::OFF_EV_STAT: next_bresp = swc_pkg::RESP_OKAY; // Read-only, write ignored
                default:              next_bresp = swc_pkg::RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = swc_pkg::RESP_OKAY;
            case (araddr)
                swc_pkg::OFF_CTRL:    next_rdata = {28'h0000000, ctrl};
                swc_pkg::OFF_STATUS:  next_rdata = {27'h0000000, ostBusy, state == swc_pkg::ST_SLEEP,
                                                    wakeByIrq, powerdownFlag, timeoutFlag};
                swc_pkg::OFF_SRC_EN:  next_rdata = {23'h000000, srcEn};
                swc_pkg::OFF_EV_STAT: next_rdata = {27'h0000000, evStat};
                swc_pkg::OFF_EV_EN:   next_rdata = {27'h0000000, evEn};
                swc_pkg::OFF_EV_CLR:  next_rdata = 32'h00000000;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = swc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // One write and one read in flight; ready only when a slot is free
        next_awready = !next_awHeld && !next_bvalid;
        next_wready  = !next_wHeld && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Sleep and wake sequence
    always_comb begin
        next_state         = state;
        next_prefetchReq   = 1'b0;
        next_coreClkEn     = coreClkEn;
        next_resumeCore    = 1'b0;
        next_takeVector    = 1'b0;
        next_deviceReset   = 1'b0;
        next_timeoutFlag   = timeoutFlag;
        next_powerdownFlag = powerdownFlag;
        next_wdtClear      = 1'b0;
        next_oscDriverEn   = oscDriverEn;
        next_ioHold        = ioHold;
        next_wakeByIrq     = wakeByIrq;
        ostStart           = 1'b0;
        evSet              = 5'h00;
        // Pending seen one cycle earlier counts as before the instruction
        next_pendPrev      = irqWake || clockedIrq;
        if (state != swc_pkg::ST_RUN && !extResetPinN) begin
            next_deviceReset = 1'b1; // RULE1
            next_coreClkEn   = 1'b1;
            next_oscDriverEn = 1'b1;
            next_ioHold      = 1'b0;
            next_state       = swc_pkg::ST_RUN;
            evSet[swc_pkg::EV_WAKE_RST] = 1'b1;
        end else begin
            case (state)
                swc_pkg::ST_RUN: begin
                    if (sleepInstr && pendPrev) begin
                        evSet[swc_pkg::EV_SLEEP_NOP] = 1'b1; // RULE11 RULE15
                    end else if (sleepInstr) begin
                        next_state         = swc_pkg::ST_SLEEP;
                        next_powerdownFlag = 1'b0; // RULE3 RULE12
                        next_timeoutFlag   = 1'b1; // RULE12
                        next_wdtClear      = 1'b1; // RULE12
                        next_prefetchReq   = 1'b1; // RULE7
                        next_coreClkEn     = 1'b0; // RULE17
                        next_oscDriverEn   = 1'b0; // RULE16
                        next_ioHold        = 1'b1; // RULE16
                        evSet[swc_pkg::EV_SLEEP] = 1'b1;
                    end
                end
                swc_pkg::ST_SLEEP: begin
                    // Clock stays off until one of the wake conditions below or the reset pin above
                    if (wdtTimeout || irqWake) begin
                        next_wdtClear    = 1'b1; // RULE13
                        next_oscDriverEn = 1'b1;
                        next_wakeByIrq   = !wdtTimeout && irqWake; // RULE2
                        if (wdtTimeout) begin
                            next_timeoutFlag = 1'b0; // RULE4
                            evSet[swc_pkg::EV_WAKE_WDT] = 1'b1;
                        end else begin
                            evSet[swc_pkg::EV_WAKE_IRQ] = 1'b1; // RULE12
                        end
                        if (crystal) begin
                            ostStart   = 1'b1; // RULE14
                            next_state = swc_pkg::ST_OST;
                        end else begin
                            next_state = swc_pkg::ST_RESUME;
                        end
                    end
                end
                swc_pkg::ST_OST: begin
                    // Watchdog held clear until the start-up count ends
                    next_wdtClear = 1'b1;
                    if (ostDone) begin
                        next_state = swc_pkg::ST_RESUME; // RULE14
                    end
                end
                swc_pkg::ST_RESUME: begin
                    next_coreClkEn  = 1'b1;
                    next_ioHold     = 1'b0;
                    next_resumeCore = 1'b1; // RULE2 RULE9
                    next_takeVector = wakeByIrq && global_irq_enable; // RULE10
                    next_state      = swc_pkg::ST_RUN;
                end
                default: begin
                    next_state     = swc_pkg::ST_RUN;
                    next_coreClkEn = 1'b1;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        next_evStat = (evStat & ~evClr) | evSet;
        next_irq    = |(next_evStat & evEn);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state         <= swc_pkg::ST_RUN;
            ctrl          <= swc_pkg::CTRL_RESET;
            srcEn         <= swc_pkg::SRC_EN_RESET;
            evStat        <= swc_pkg::EV_RESET;
            evEn          <= swc_pkg::EV_RESET;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            wrAddr        <= 5'h00;
            wrData        <= 32'h00000000;
            wrStrb        <= 4'h0;
            awready       <= 1'b1;
            wready        <= 1'b1;
            bvalid        <= 1'b0;
            bresp         <= swc_pkg::RESP_OKAY;
            arready       <= 1'b1;
            rvalid        <= 1'b0;
            rdata         <= 32'h00000000;
            rresp         <= swc_pkg::RESP_OKAY;
            irq           <= 1'b0;
            pendPrev      <= 1'b0;
            wakeByIrq     <= 1'b0;
            prefetchReq   <= 1'b0;
            coreClkEn     <= 1'b1;
            resumeCore    <= 1'b0;
            takeVector    <= 1'b0;
            vectorAddr    <= swc_pkg::VECTOR_ADDR;
            deviceReset   <= 1'b0;
            timeoutFlag   <= 1'b1;
            powerdownFlag <= 1'b1; // RULE3
            wdtClear      <= 1'b0;
            oscDriverEn   <= 1'b1;
            ioHold        <= 1'b0;
        end else begin
            state         <= next_state;
            ctrl          <= next_ctrl;
            srcEn         <= next_srcEn;
            evStat        <= next_evStat;
            evEn          <= next_evEn;
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            wrAddr        <= next_wrAddr;
            wrData        <= next_wrData;
            wrStrb        <= next_wrStrb;
            awready       <= next_awready;
            wready        <= next_wready;
            bvalid        <= next_bvalid;
            bresp         <= next_bresp;
            arready       <= next_arready;
            rvalid        <= next_rvalid;
            rdata         <= next_rdata;
            rresp         <= next_rresp;
            irq           <= next_irq;
            pendPrev      <= next_pendPrev;
            wakeByIrq     <= next_wakeByIrq;
            prefetchReq   <= next_prefetchReq;
            coreClkEn     <= next_coreClkEn;
            resumeCore    <= next_resumeCore;
            takeVector    <= next_takeVector;
            vectorAddr    <= swc_pkg::VECTOR_ADDR;
            deviceReset   <= next_deviceReset;
            timeoutFlag   <= next_timeoutFlag;
            powerdownFlag <= next_powerdownFlag;
            wdtClear      <= next_wdtClear;
            oscDriverEn   <= next_oscDriverEn;
            ioHold        <= next_ioHold;
        end
    end

    // Checks on the sequence
    property p_resetWake;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_SLEEP && !extResetPinN) |=> (deviceReset && state == swc_pkg::ST_RUN && coreClkEn);
    endproperty
    a_resetWake: assert property (p_resetWake) else $error("reset pin did not reset from sleep"); // RULE1

    property p_irqNoReset;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_SLEEP && extResetPinN && !wdtTimeout && irqWake && !crystal)
        |=> !deviceReset ##1 (resumeCore && !deviceReset);
    endproperty
    a_irqNoReset: assert property (p_irqNoReset) else $error("interrupt wake did not resume"); // RULE2

    property p_sleepEnter;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_RUN && sleepInstr && !pendPrev)
        |=> (!powerdownFlag && timeoutFlag && wdtClear && prefetchReq && !oscDriverEn && ioHold);
    endproperty
    a_sleepEnter: assert property (p_sleepEnter) else $error("sleep entry effects missing"); // RULE3

    property p_wdtWake;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_SLEEP && extResetPinN && wdtTimeout) |=> (!timeoutFlag && wdtClear);
    endproperty
    a_wdtWake: assert property (p_wdtWake) else $error("watchdog wake left timeout flag set"); // RULE4

    property p_enableGate;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_SLEEP && extResetPinN && !wdtTimeout && (srcFlag & srcEn) == 9'h000)
        |=> (state == swc_pkg::ST_SLEEP && !coreClkEn);
    endproperty
    a_enableGate: assert property (p_enableGate) else $error("woke without an enabled source"); // RULE8

    property p_inline;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_RESUME && extResetPinN && !global_irq_enable) |=> (resumeCore && !takeVector);
    endproperty
    a_inline: assert property (p_inline) else $error("vector taken with global enable clear"); // RULE9

    property p_vector;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_RESUME && extResetPinN && global_irq_enable && wakeByIrq)
        |=> (takeVector && resumeCore && vectorAddr == 13'h0004);
    endproperty
    a_vector: assert property (p_vector) else $error("vector branch missing"); // RULE10

    property p_sleepNop;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_RUN && sleepInstr && pendPrev)
        |=> (state == swc_pkg::ST_RUN && powerdownFlag == $past(powerdownFlag) && !wdtClear && coreClkEn);
    endproperty
    a_sleepNop: assert property (p_sleepNop) else $error("sleep with pending interrupt not a no-op"); // RULE11

    // Cycles spent in start-up; a delay range this long would be too slow to check
    logic [10:0] ostCycles;
    logic [10:0] next_ostCycles;

    always_comb begin
        next_ostCycles = inOst ? ostCycles + 11'h001 : 11'h000;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ostCycles <= 11'h000;
        end else begin
            ostCycles <= next_ostCycles;
        end
    end

    property p_ostLen;
        @(posedge mclk) disable iff (!nrst)
        inOst |-> (!coreClkEn && wdtClear && ostCycles <= 11'(swc_pkg::OST_CYCLES)
                   && (ostDone == (ostCycles == 11'(swc_pkg::OST_CYCLES))));
    endproperty
    a_ostLen: assert property (p_ostLen) else $error("start-up delay wrong length"); // RULE14 RULE13

    property p_clockGate;
        @(posedge mclk) disable iff (!nrst)
        (state == swc_pkg::ST_SLEEP) |-> (!coreClkEn && !resumeCore);
    endproperty
    a_clockGate: assert property (p_clockGate) else $error("core clock running while asleep"); // RULE17
endmodule : swc_sleep_wakeup_control
`default_nettype wire

//--- core/swc_pkg.sv
`default_nettype none
package swc_pkg;
    // Register map, byte addresses on the AXI4-Lite slave
    localparam logic [4:0]  OFF_CTRL     = 5'h00;
    localparam logic [4:0]  OFF_STATUS   = 5'h04;
    localparam logic [4:0]  OFF_SRC_EN   = 5'h08;
    localparam logic [4:0]  OFF_EV_STAT  = 5'h0c;
    localparam logic [4:0]  OFF_EV_CLR   = 5'h10;
    localparam logic [4:0]  OFF_EV_EN    = 5'h14;

    // Control register fields
    localparam int          CTRL_GIE     = 0;
    localparam int          CTRL_MODE_LO = 1;
    localparam int          CTRL_W       = 4;
    localparam logic [3:0]  CTRL_RESET   = 4'h0;

    // Oscillator modes held in the control register
    localparam logic [2:0]  MODE_EXT_CLOCK = 3'h0;
    localparam logic [2:0]  MODE_RC        = 3'h1;
    localparam logic [2:0]  MODE_CRYSTAL   = 3'h2;
    localparam logic [2:0]  MODE_HS_CRYSTAL = 3'h3;
    localparam logic [2:0]  MODE_LP_CRYSTAL = 3'h4;

    // Wake-capable sources, one bit each
    localparam int          NSRC        = 9;
    localparam int          SRC_TIMER1  = 0;
    localparam int          SRC_SERIAL  = 1;
    localparam int          SRC_ADC_RC  = 2;
    localparam int          SRC_EEPROM  = 3;
    localparam int          SRC_COMP    = 4;
    localparam int          SRC_CHANGE  = 5;
    localparam int          SRC_EXT_IRQ = 6;
    localparam int          SRC_LVD     = 7;
    localparam int          SRC_LCD     = 8;
    localparam logic [8:0]  SRC_EN_RESET = 9'h000;

    // Event status bits
    localparam int          NEV          = 5;
    localparam int          EV_SLEEP     = 0;
    localparam int          EV_SLEEP_NOP = 1;
    localparam int          EV_WAKE_WDT  = 2;
    localparam int          EV_WAKE_IRQ  = 3;
    localparam int          EV_WAKE_RST  = 4;
    localparam logic [4:0]  EV_RESET     = 5'h00;

    // Start-up delay: oscillator periods, the oscillator taken at the mclk rate
    localparam int          OST_PERIODS   = 1024;
    localparam int          OSC_PERIOD_NS = 40;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          OST_CYCLES    = (OST_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] OST_LOAD      = 11'(OST_CYCLES - 1);

    localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [3:0] {
        ST_RUN    = 4'h1,
        ST_SLEEP  = 4'h2,
        ST_OST    = 4'h4,
        ST_RESUME = 4'h8
    } swc_state_t;
endpackage : swc_pkg
`default_nettype wire

//--- core/swc_ost_timer.sv
`timescale 1ns/1ns
`default_nettype none
module swc_ost_timer (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    logic [10:0] count;
    logic [10:0] next_count;
    logic        next_busy;
    logic        next_done;

    // Down-counter, reloaded on every start
    always_comb begin
        next_count = count;
        next_busy  = busy;
        next_done  = 1'b0;
        if (start) begin
            next_count = swc_pkg::OST_LOAD;
            next_busy  = 1'b1;
        end else if (busy) begin
            if (count == 11'h000) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 11'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= 11'h000;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            busy  <= next_busy;
            done  <= next_done;
        end
    end
endmodule : swc_ost_timer
`default_nettype wire

//--- bench/swc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module swc_core_model (
    // Clock and bench command
    input  wire logic mclk,
    input  wire logic go,
    // Sleep instruction to the block
    output logic      sleepInstr
);
    // Registered like a fetch stage, so the pulse is one cycle late
    always_ff @(posedge mclk) sleepInstr <= go;
endmodule : swc_core_model
`default_nettype wire

//--- bench/sleep_wakeup_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sleep_wakeup_control_tb;
    // Stimulus and observed outputs
    logic mclk = 0, nrst = 0, go = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic extResetPinN = 1, wdtTimeout = 0, clockedIrq = 0, sleepInstr, awready, wready, bvalid, arready, rvalid;
    logic prefetchReq, coreClkEn, resumeCore, takeVector, deviceReset, timeoutFlag, powerdownFlag;
    logic wdtClear, oscDriverEn, ioHold, irq;
    logic [1:0] bresp, rresp;
    logic [4:0] awaddr = 0, araddr = 0;
    logic [8:0] srcFlag = 0;
    logic [12:0] vectorAddr;
    logic [31:0] wdata = 0, rdata;
    int failures = 0, total_checks = 0, cyc = 0;
    // 25 MHz clock
    always #20 mclk = ~mclk;
    swc_core_model core (.*);
    swc_sleep_wakeup_control uut (.*, .wstrb(4'hf));
    task automatic chk(input string n, input logic [31:0] e, s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Bus write, both channels offered together
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", swc_pkg::RESP_OKAY, bresp);
    endtask : wr
    // Bus read; response code packed above the data
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk("read", e, {rresp, rdata[29:0]});
    endtask : rd
    // Sleep, tempt with a clocked source, then wake; n bounds the wait
    task automatic nap(input logic [8:0] f, input logic w, p, tv, input int lo, hi);
        int n;
        logic clr;
        clr = 0;
        @(posedge mclk);
        go <= 1;
        @(posedge mclk);
        go <= 0;
        @(posedge mclk);
        #1 chk("asleep", 6'h26, {timeoutFlag, powerdownFlag, coreClkEn, prefetchReq, ioHold, oscDriverEn});
        @(posedge mclk);
        clockedIrq <= 1;
        repeat (3) @(posedge mclk);
        {srcFlag, wdtTimeout, extResetPinN, clockedIrq} <= {f, w, !p, 1'b0};
        for (n = 1; n < 1100 && !(resumeCore | deviceReset); n++) begin
            @(posedge mclk);
            #1 clr |= wdtClear;
        end
        chk("wake", {tv, p, 2'h3}, {takeVector, deviceReset, clr | p, n > lo && n <= hi + 1});
        @(posedge mclk);
        {srcFlag, wdtTimeout, extResetPinN} <= {9'h0, 2'h1};
    endtask : nap
    task automatic s_boot;
        @(posedge mclk);
        nrst <= 0;
        repeat (4) @(posedge mclk);
        nrst <= 1;
        #1 chk("boot", 4'hf, {powerdownFlag, timeoutFlag, coreClkEn, oscDriverEn});
    endtask : s_boot
    // Flag already up before sleep: nothing may change
    task automatic s_noop;
        wr(swc_pkg::OFF_SRC_EN, 32'h1ff);
        @(posedge mclk);
        {srcFlag, go} <= {9'h1, 1'b1};
        @(posedge mclk);
        go <= 0;
        repeat (2) @(posedge mclk);
        #1 chk("noop", 3'h7, {powerdownFlag, timeoutFlag, coreClkEn});
        @(posedge mclk);
        srcFlag <= 0;
    endtask : s_noop
    task automatic s_sources;
        wr(swc_pkg::OFF_CTRL, 32'h0);
        for (int i = 0; i < swc_pkg::NSRC; i++) nap(9'(1 << i), 0, 0, 0, 2, 2);
    endtask : s_sources
    task automatic s_modes;
        wr(swc_pkg::OFF_CTRL, 32'h3);
        nap(9'h40, 0, 0, 1, 2, 2);
        chk("vector", 13'h0004, vectorAddr);
        nap(9'h0, 1, 0, 0, 2, 2);
        chk("timeout", 0, timeoutFlag);
        wr(swc_pkg::OFF_CTRL, 32'h4);
        nap(9'h8, 0, 0, 0, 1026, 1028);
    endtask : s_modes
    task automatic s_events;
        rd(swc_pkg::OFF_SRC_EN, 32'h1ff);
        wr(swc_pkg::OFF_EV_EN, 32'h1);
        repeat (2) @(posedge mclk);
        #1 chk("irq", 1, irq);
        wr(swc_pkg::OFF_EV_CLR, 32'h1f);
        repeat (2) @(posedge mclk);
        #1 chk("irq", 0, irq);
        rd(swc_pkg::OFF_EV_STAT, 32'h0);
        rd(5'h1c, 32'h8000_0000);
    endtask : s_events
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // Hang guard, well above the longest start-up wait
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        s_boot;
        s_noop;
        s_sources;
        s_modes;
        s_events;
        nap(9'h0, 0, 1, 0, 1, 2);
        s_boot;
        close_out;
    end
endmodule : sleep_wakeup_control_tb
`default_nettype wire
